// File: rtl/sfmc_core.sv
`timescale 1ns/100ps
`default_nettype none
module sfmc_core (
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        spi_cs_n_in,
    input  wire logic        spi_sclk_in,
    input  wire logic        flash_reset_n_in,
    input  wire logic [3:0]  quad_data_lines_in,
    output logic      [3:0]  quad_data_lines_out,
    output logic      [3:0]  quad_data_lines_oe_out,
    output logic      [31:0] read_addr_out,
    output logic             read_start_out
);

    // ************************************************
    // declarations
    // ************************************************
    logic [6:0]  sync1;
    logic [6:0]  sync2;
    logic        sclk_d;
    logic        cs_d;
    logic        ctrl_en;
    logic        qpi_mode;
    logic        four_byte;
    logic        cont_read;
    logic        wel;
    logic        vol_we;
    logic        vol_active;
    logic        rst_en;
    logic [7:0]  ext_addr;
    logic [7:0]  sr1_nv;
    logic [7:0]  sr1_vol;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift_in;
    logic [7:0]  cmd;
    logic        cmd_ok;
    logic [2:0]  byte_cnt;
    logic [31:0] addr;
    logic [7:0]  wdata;
    logic [1:0]  wcnt;
    logic        mode_seen;
    logic        mode_keep;
    logic [3:0]  ff_cnt;
    logic        rescue;
    logic [7:0]  out_sh;
    sfmc_pkg::sfmc_phase_e phase;
    sfmc_pkg::sfmc_phase_e cmd_phase;

    // ************************************************
    // pin synchronisers
    // ************************************************
    // two stages for every pin, only sync2 is read
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sync1 <= sfmc_pkg::SYNC_RESET;
            sync2 <= sfmc_pkg::SYNC_RESET;
        end
        else
        begin
            sync1 <= {flash_reset_n_in, spi_cs_n_in, spi_sclk_in, quad_data_lines_in};
            sync2 <= sync1;
        end
    end

    // edge history of the synchronised clock and chip select pins
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sclk_d <= 1'b0;
            cs_d   <= 1'b1;
        end
        else
        begin
            sclk_d <= sync2[4];
            cs_d   <= sync2[5];
        end
    end

    // ************************************************
    // link decode
    // ************************************************
    // reset pin is always honoured, nothing masks it
    wire       pin_rst_n  = sync2[6];
    wire       cs_n       = sync2[5];
    wire       sclk       = sync2[4];
    wire [3:0] dq         = sync2[3:0];
    wire       link_on    = ctrl_en & pin_rst_n;
    wire       sclk_rise  = sclk & ~sclk_d & ~cs_n;
    wire       sclk_fall  = ~sclk & sclk_d & ~cs_n;
    wire       cs_fall    = ~cs_n & cs_d;
    wire       cs_rise    = cs_n & ~cs_d;
    wire       active     = link_on & (phase != sfmc_pkg::PH_IDLE);

    // lane count: quad in quad mode and on the quad read path
    wire quad_now = qpi_mode | (phase == sfmc_pkg::PH_ADDR) | (phase == sfmc_pkg::PH_MODE);
    wire [3:0] next_bits = bit_cnt + (quad_now ? 4'h4 : 4'h1);
    wire       byte_done = (next_bits == 4'h8);
    wire [7:0] next_shift = quad_now ? {shift_in[3:0], dq} : {shift_in[6:0], dq[0]};

    // status register view, low two bits status only
    wire [7:0] sr1_eff  = vol_active ? sr1_vol : sr1_nv;
    wire [7:0] sr1_read = {sr1_eff[7:2], wel, 1'b0};
    wire       qe       = sr1_eff[sfmc_pkg::QE_POS];
    wire [2:0] addr_bytes = four_byte ? 3'h4 : 3'h3;
    wire [3:0] rescue_clks = four_byte ? sfmc_pkg::RESCUE_CLK_4B : sfmc_pkg::RESCUE_CLK_3B;
    wire       dq_all_f = (dq == sfmc_pkg::RESCUE_NIB);
    wire       ff_hit   = dq_all_f & (ff_cnt != sfmc_pkg::FF_BROKEN) & ((ff_cnt + 4'h1) == rescue_clks);

    // frame end decode
    wire end_ok  = cs_rise & cmd_ok & link_on;
    wire do_soft = end_ok & (cmd == sfmc_pkg::CMD_RESET) & rst_en;
    wire dev_rst = ~pin_rst_n | do_soft;
    wire [7:0] sr1_new = wdata & sfmc_pkg::SR1_WR_MASK;

    // phase that follows each instruction byte
    assign cmd_phase =
        ((next_shift == sfmc_pkg::CMD_WRSR) || (next_shift == sfmc_pkg::CMD_WR_EXT)) ? sfmc_pkg::PH_WDATA :
        ((next_shift == sfmc_pkg::CMD_RDSR) || (next_shift == sfmc_pkg::CMD_RD_EXT)) ? sfmc_pkg::PH_RDATA :
        ((next_shift == sfmc_pkg::CMD_QREAD) && qe) ? sfmc_pkg::PH_ADDR :
        sfmc_pkg::PH_IGN;

    // segment mapping of a 24-bit address
    wire [31:0] map_addr = four_byte ? addr : {ext_addr, addr[23:0]};

    // ************************************************
    // frame engine
    // ************************************************
    // frame start, bit collection and phase steps
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            phase          <= sfmc_pkg::PH_IDLE;
            bit_cnt        <= 4'h0;
            shift_in       <= 8'h00;
            cmd            <= 8'h00;
            cmd_ok         <= 1'b0;
            byte_cnt       <= 3'h0;
            addr           <= 32'h0000_0000;
            wdata          <= 8'h00;
            wcnt           <= 2'h0;
            mode_seen      <= 1'b0;
            mode_keep      <= 1'b0;
            ff_cnt         <= sfmc_pkg::FF_BROKEN;
            rescue         <= 1'b0;
            read_start_out <= 1'b0;
            read_addr_out  <= 32'h0000_0000;
        end
        else
        begin
            read_start_out <= 1'b0;
            if (cs_rise | ~link_on)
            begin
                phase <= sfmc_pkg::PH_IDLE;
            end
            else if (cs_fall)
            begin
                // continuous read frames skip the instruction
                phase     <= cont_read ? sfmc_pkg::PH_ADDR : sfmc_pkg::PH_CMD;
                cmd       <= sfmc_pkg::CMD_QREAD;
                cmd_ok    <= cont_read;
                ff_cnt    <= cont_read ? 4'h0 : sfmc_pkg::FF_BROKEN;
                bit_cnt   <= 4'h0;
                byte_cnt  <= 3'h0;
                addr      <= 32'h0000_0000;
                wcnt      <= 2'h0;
                mode_seen <= 1'b0;
                rescue    <= 1'b0;
            end
            else if (sclk_rise & active)
            begin
                bit_cnt  <= byte_done ? 4'h0 : next_bits;
                shift_in <= next_shift;
                // run of all-ones nibbles from the frame start
                if (ff_cnt != sfmc_pkg::FF_BROKEN)
                begin
                    ff_cnt <= dq_all_f ? ff_cnt + 4'h1 : sfmc_pkg::FF_BROKEN;
                end
                if (ff_hit)
                begin
                    rescue <= 1'b1;
                    phase  <= sfmc_pkg::PH_IGN;
                end
                else if (byte_done)
                begin
                    case (phase)
                        sfmc_pkg::PH_CMD:
                        begin
                            cmd    <= next_shift;
                            cmd_ok <= 1'b1;
                            phase  <= cmd_phase;
                        end
                        sfmc_pkg::PH_ADDR:
                        begin
                            addr     <= {addr[23:0], next_shift};
                            byte_cnt <= byte_cnt + 3'h1;
                            if ((byte_cnt + 3'h1) == addr_bytes)
                            begin
                                phase <= sfmc_pkg::PH_MODE;
                            end
                        end
                        sfmc_pkg::PH_MODE:
                        begin
                            mode_seen      <= 1'b1;
                            mode_keep      <= (next_shift[7:4] == sfmc_pkg::MODE_KEEP_NIB);
                            phase          <= sfmc_pkg::PH_IGN;
                            read_start_out <= 1'b1;
                            read_addr_out  <= map_addr;
                        end
                        sfmc_pkg::PH_WDATA:
                        begin
                            if (wcnt == 2'h0)
                            begin
                                wdata <= next_shift;
                            end
                            wcnt <= (wcnt == 2'h2) ? 2'h2 : wcnt + 2'h1;
                        end
                        default:
                        begin
                            phase <= phase;
                        end
                    endcase
                end
            end
        end
    end

    // ************************************************
    // mode state
    // ************************************************
    // instruction effects at the end of each frame
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            qpi_mode   <= 1'b0;
            four_byte  <= 1'b0;
            cont_read  <= 1'b0;
            wel        <= 1'b0;
            vol_we     <= 1'b0;
            rst_en     <= 1'b0;
            ext_addr   <= sfmc_pkg::EXT_RESET;
            vol_active <= 1'b0;
            sr1_vol    <= sfmc_pkg::SR1_NV_INIT;
            sr1_nv     <= sfmc_pkg::SR1_NV_INIT;
        end
        else if (dev_rst)
        begin
            // volatile status copy survives until power off
            qpi_mode  <= 1'b0;
            four_byte <= 1'b0;
            cont_read <= 1'b0;
            wel       <= 1'b0;
            vol_we    <= 1'b0;
            rst_en    <= 1'b0;
            ext_addr  <= sfmc_pkg::EXT_RESET;
        end
        else if (cs_rise)
        begin
            rst_en <= end_ok & (cmd == sfmc_pkg::CMD_RST_EN);
            if (mode_seen)
            begin
                cont_read <= mode_keep;
            end
            if (rescue)
            begin
                cont_read <= 1'b0;
            end
            if (end_ok)
            begin
                case (cmd)
                    sfmc_pkg::CMD_WREN:      wel <= 1'b1;
                    sfmc_pkg::CMD_VWREN:     vol_we <= 1'b1;
                    sfmc_pkg::CMD_EXIT_QPI:  qpi_mode <= 1'b0;
                    sfmc_pkg::CMD_ENTER_QPI: qpi_mode <= qpi_mode | qe;
                    sfmc_pkg::CMD_EN4B:      four_byte <= 1'b1;
                    sfmc_pkg::CMD_EX4B:      four_byte <= 1'b0;
                    sfmc_pkg::CMD_WR_EXT:
                    begin
                        if (wcnt == 2'h1)
                        begin
                            ext_addr <= wdata;
                        end
                    end
                    sfmc_pkg::CMD_WRSR:
                    begin
                        if (wcnt != 2'h0)
                        begin
                            if (vol_we)
                            begin
                                sr1_vol    <= sr1_new;
                                vol_active <= 1'b1;
                            end
                            else if (wel)
                            begin
                                sr1_nv <= sr1_new;
                            end
                            wel    <= 1'b0;
                            vol_we <= 1'b0;
                        end
                    end
                    default:
                    begin
                        wel <= wel;
                    end
                endcase
            end
        end
    end

    // ************************************************
    // read data driver
    // ************************************************
    // shift out on falling clock, byte repeats
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            out_sh                 <= 8'h00;
            quad_data_lines_out    <= 4'h0;
            quad_data_lines_oe_out <= 4'h0;
        end
        else if (~active)
        begin
            quad_data_lines_oe_out <= 4'h0;
        end
        else if (sclk_rise & byte_done & (phase == sfmc_pkg::PH_CMD))
        begin
            out_sh <= (next_shift == sfmc_pkg::CMD_RD_EXT) ? ext_addr : sr1_read;
        end
        else if (sclk_fall & (phase == sfmc_pkg::PH_RDATA))
        begin
            if (qpi_mode)
            begin
                quad_data_lines_out    <= out_sh[7:4];
                quad_data_lines_oe_out <= 4'hF;
                out_sh                 <= {out_sh[3:0], out_sh[7:4]};
            end
            else
            begin
                quad_data_lines_out    <= {2'b00, out_sh[7], 1'b0};
                quad_data_lines_oe_out <= 4'h2;
                out_sh                 <= {out_sh[6:0], out_sh[7]};
            end
        end
    end

    // ************************************************
    // wishbone slave
    // ************************************************
    wire        bus_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    wire [3:0]  reg_ofs  = {wb_adr_in[3:2], 2'b00};
    wire [31:0] stat_word = {8'h00, sr1_read, ext_addr, 1'b0, rst_en, vol_active, vol_we,
                             wel, cont_read, four_byte, qpi_mode};
    wire [31:0] rd_word  = (reg_ofs == sfmc_pkg::OFS_CTRL)   ? {31'h0000_0000, ctrl_en} :
                           (reg_ofs == sfmc_pkg::OFS_STATUS) ? stat_word :
                           (reg_ofs == sfmc_pkg::OFS_ADDR)   ? read_addr_out : 32'h0000_0000;

    // one wait state answer, control write on lane 0
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
            ctrl_en    <= sfmc_pkg::CTRL_RESET;
        end
        else
        begin
            wb_ack_out <= bus_req;
            wb_dat_out <= bus_req ? rd_word : wb_dat_out;
            if (bus_req & wb_we_in & wb_sel_in[0] & (reg_ofs == sfmc_pkg::OFS_CTRL))
            begin
                ctrl_en <= wb_dat_in[0];
            end
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_end(logic [7:0] c);
        end_ok && pin_rst_n && (cmd == c);
    endsequence

    sequence s_pin_low;
        !pin_rst_n [*2];
    endsequence

    a_qpi_exit: assert property (s_end(sfmc_pkg::CMD_EXIT_QPI) |=> !qpi_mode)
        else $error("quad mode kept after exit");
    a_qpi_enter: assert property (s_end(sfmc_pkg::CMD_ENTER_QPI) and qe |=> qpi_mode)
        else $error("quad mode not entered");
    a_soft_reset: assert property (s_end(sfmc_pkg::CMD_RESET) and rst_en
        |=> !qpi_mode && !four_byte && !cont_read && (ext_addr == 8'h00))
        else $error("soft reset incomplete");
    a_rst_enable: assert property (s_end(sfmc_pkg::CMD_RST_EN)
        |=> rst_en ##1 (rst_en || cs_rise || $past(dev_rst)))
        else $error("reset enable not held");
    a_four_enter: assert property (s_end(sfmc_pkg::CMD_EN4B) |=> four_byte)
        else $error("4-byte mode not entered");
    a_four_exit: assert property (s_end(sfmc_pkg::CMD_EX4B) |=> !four_byte)
        else $error("4-byte mode not left");
    a_ext_write: assert property (s_end(sfmc_pkg::CMD_WR_EXT) and (wcnt == 2'h1)
        |=> ext_addr == $past(wdata))
        else $error("extended address not written");
    a_ext_reject: assert property (s_end(sfmc_pkg::CMD_WR_EXT) and (wcnt == 2'h2) |=> $stable(ext_addr))
        else $error("long extended write taken");
    a_mode_exit: assert property (cs_rise && mode_seen && !mode_keep |=> !cont_read)
        else $error("continuous read kept");
    a_mode_keep: assert property (cs_rise && mode_seen && mode_keep && !rescue && !dev_rst
        |=> cont_read ##1 (cont_read || $past(dev_rst)))
        else $error("continuous read not entered");
    a_rescue_exit: assert property (cs_rise && rescue |=> !cont_read)
        else $error("rescue pattern ignored");
    a_nv_guard: assert property (s_end(sfmc_pkg::CMD_WRSR) and !wel && !vol_we |=> $stable(sr1_nv))
        else $error("status written without enable");
    a_hw_reset: assert property (s_pin_low |-> !four_byte && !qpi_mode && (ext_addr == 8'h00))
        else $error("reset pin not obeyed");
    a_segment_map: assert property (read_start_out && !four_byte |-> read_addr_out[31:24] == ext_addr)
        else $error("segment not applied");

endmodule
`default_nettype wire

// File: rtl/sfmc_pkg.sv
package sfmc_pkg;

    // ************************************************
    // instruction codes
    // ************************************************
    localparam logic [7:0] CMD_EXIT_QPI  = 8'hFF;
    localparam logic [7:0] CMD_ENTER_QPI = 8'h38;
    localparam logic [7:0] CMD_RST_EN    = 8'h66;
    localparam logic [7:0] CMD_RESET     = 8'h99;
    localparam logic [7:0] CMD_EN4B      = 8'hB7;
    localparam logic [7:0] CMD_EX4B      = 8'hE9;
    localparam logic [7:0] CMD_RD_EXT    = 8'hC8;
    localparam logic [7:0] CMD_WR_EXT    = 8'hC5;
    localparam logic [7:0] CMD_WREN      = 8'h06;
    localparam logic [7:0] CMD_VWREN     = 8'h50;
    localparam logic [7:0] CMD_WRSR      = 8'h01;
    localparam logic [7:0] CMD_RDSR      = 8'h05;
    localparam logic [7:0] CMD_QREAD     = 8'hEB;

    // ************************************************
    // mode byte and rescue pattern
    // ************************************************
    localparam logic [3:0] MODE_KEEP_NIB = 4'hA;
    localparam logic [3:0] RESCUE_NIB    = 4'hF;
    localparam logic [3:0] RESCUE_CLK_3B = 4'h8;
    localparam logic [3:0] RESCUE_CLK_4B = 4'hA;
    localparam logic [3:0] FF_BROKEN     = 4'hF;

    // ************************************************
    // status register 1 layout and values
    // ************************************************
    localparam int         QE_POS        = 6;
    localparam logic [7:0] SR1_WR_MASK   = 8'hFC;
    localparam logic [7:0] SR1_NV_INIT   = 8'h00;
    localparam logic [7:0] EXT_RESET     = 8'h00;

    // ************************************************
    // bus register map and reset values
    // ************************************************
    localparam logic [3:0] OFS_CTRL      = 4'h0;
    localparam logic [3:0] OFS_STATUS    = 4'h4;
    localparam logic [3:0] OFS_ADDR      = 4'h8;
    localparam logic       CTRL_RESET    = 1'b1;
    localparam logic [6:0] SYNC_RESET    = 7'h60;

    // ************************************************
    // frame phases
    // ************************************************
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_CMD   = 3'b001,
        PH_ADDR  = 3'b010,
        PH_MODE  = 3'b011,
        PH_WDATA = 3'b100,
        PH_RDATA = 3'b101,
        PH_IGN   = 3'b110
    } sfmc_phase_e;

endpackage

// File: test/sfmc_core_test.sv
`timescale 1ns/100ps
`default_nettype none
module sfmc_core_test;
    logic        core_clk_in = 1'b0;
    logic        rstn_in     = 1'b0;
    logic        frst_n      = 1'b1;
    logic        cyc         = 1'b0;
    logic        stb         = 1'b0;
    logic        we          = 1'b0;
    logic [3:0]  adr         = 4'h0;
    logic [31:0] wdat        = 32'h0;
    logic [31:0] rdat, s, q, raddr;
    logic [3:0]  dout, doe, hdq, hoe;
    logic        ack, cs_n, sclk, rs;
    logic [7:0]  rx;
    int          n_errors    = 0;
    int          checks_done = 0;
    int          n_start     = 0;
    int          k;
    // released lanes show the inverse of their last value
    wire  [3:0]  dq = (doe & dout) | (~doe & hoe & hdq) | (~doe & ~hoe & ~hdq);
    always #20 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (rs === 1'b1) n_start++;
    sfmc_core dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .flash_reset_n_in(frst_n),
        .quad_data_lines_in(dq), .quad_data_lines_out(dout), .quad_data_lines_oe_out(doe),
        .read_addr_out(raddr), .read_start_out(rs));
    sfmc_host host (.clk_in(core_clk_in), .dq_in(dq), .cs_n_out(cs_n), .sclk_out(sclk),
        .dq_out(hdq), .oe_out(hoe), .rx_out(rx));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
        begin
            @(posedge core_clk_in);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n == 20) n_errors++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task automatic st;
        wb(1'b0, 4'h4, 32'h0);
        s = q;
    endtask
    task automatic wr2(input logic [7:0] c, input logic [7:0] d);
        host.frm_open();
        host.send(c, 1'b0);
        host.send(d, 1'b0);
        host.frm_close();
    endtask
    // quad read frame; in continuous read it starts at the address
    task automatic qrd(input logic cont, input logic [23:0] a, input logic [7:0] m);
        host.frm_open();
        if (!cont) host.send(8'hEB, 1'b0);
        host.send(a[23:16], 1'b1);
        host.send(a[15:8], 1'b1);
        host.send(a[7:0], 1'b1);
        host.send(m, 1'b1);
        host.frm_close();
    endtask
    task automatic t_reset;
        wb(1'b0, 4'h0, 32'h0);
        chk("ctrl", q, 32'h1);
        wb(1'b1, 4'h4, 32'hFF);
        st();
        chk("status", s, 32'h0);
        wb(1'b0, 4'hC, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b1, 4'h0, 32'h0);
        host.put(8'hB7, 1'b0);
        wb(1'b1, 4'h0, 32'h1);
        st();
        chk("link_off", s[1], 1'b0);
        $display("t_reset done");
    endtask
    task automatic t_addr;
        host.put(8'hB7, 1'b0);
        st();
        chk("four_byte", s[3:0], 4'h2);
        host.put(8'hE9, 1'b0);
        st();
        chk("three_byte", s[3:0], 4'h0);
        $display("t_addr done");
    endtask
    task automatic t_ext;
        wr2(8'hC5, 8'h5A);
        st();
        chk("ext_write", s[15:8], 8'h5A);
        host.frm_open();
        host.send(8'hC8, 1'b0);
        host.recv();
        host.frm_close();
        chk("ext_read", rx, 8'h5A);
        host.frm_open();
        host.send(8'hC5, 1'b0);
        host.send(8'h11, 1'b0);
        host.send(8'h22, 1'b0);
        host.frm_close();
        st();
        chk("ext_two_bytes", s[15:8], 8'h5A);
        wr2(8'hC5, 8'h00);
        st();
        chk("ext_lowest", s[15:8], 8'h00);
        $display("t_ext done");
    endtask
    task automatic t_sr;
        wr2(8'h01, 8'h40);
        st();
        chk("sr_no_enable", s[23:16], 8'h00);
        host.put(8'h38, 1'b0);
        st();
        chk("quad_needs_qe", s[0], 1'b0);
        host.put(8'h06, 1'b0);
        st();
        chk("wel", s[3], 1'b1);
        wr2(8'h01, 8'h40);
        st();
        chk("sr_written", s[23:16], 8'h40);
        host.put(8'h38, 1'b0);
        st();
        chk("quad_on", s[0], 1'b1);
        host.put(8'hFF, 1'b1);
        st();
        chk("quad_exit", s[0], 1'b0);
        host.put(8'h38, 1'b0);
        host.put(8'h66, 1'b1);
        host.put(8'h99, 1'b1);
        st();
        chk("quad_soft_reset", s[0], 1'b0);
        $display("t_sr done");
    endtask
    task automatic t_rst;
        host.put(8'hB7, 1'b0);
        wr2(8'hC5, 8'h12);
        host.put(8'h66, 1'b0);
        host.put(8'h99, 1'b0);
        st();
        chk("soft_reset", s[15:0], 16'h0);
        host.put(8'hB7, 1'b0);
        frst_n <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        frst_n <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        st();
        chk("pin_reset", s[1], 1'b0);
        $display("t_rst done");
    endtask
    task automatic t_cont;
        wr2(8'hC5, 8'h03);
        k = n_start;
        qrd(1'b0, 24'h123456, 8'hA5);
        chk("start_pulse", n_start - k, 32'h1);
        chk("mapped", raddr, 32'h03123456);
        st();
        chk("cont_on", s[2], 1'b1);
        qrd(1'b1, 24'h000010, 8'hA0);
        st();
        chk("cont_keep", s[2], 1'b1);
        qrd(1'b1, 24'h000020, 8'h00);
        st();
        chk("mode_zero", s[2], 1'b0);
        qrd(1'b0, 24'h000030, 8'hA5);
        qrd(1'b1, 24'h000040, 8'h3C);
        st();
        chk("mode_other", s[2], 1'b0);
        qrd(1'b0, 24'h000050, 8'hA5);
        host.frm_open();
        repeat (8) host.tick(4'hF, 4'hF);
        host.frm_close();
        st();
        chk("rescue", s[2], 1'b0);
        host.put(8'hB7, 1'b0);
        host.frm_open();
        host.send(8'hEB, 1'b0);
        repeat (5) host.send(8'hA5, 1'b1);
        host.frm_close();
        st();
        chk("cont_4b", s[2:1], 2'h3);
        host.frm_open();
        repeat (10) host.tick(4'hF, 4'hF);
        host.frm_close();
        st();
        chk("rescue_4b", s[2:1], 2'h1);
        $display("t_cont done");
    endtask
    task automatic t_vol;
        host.put(8'h50, 1'b0);
        wr2(8'h01, 8'h44);
        st();
        chk("vol_active", s[5], 1'b1);
        chk("vol_value", s[23:16], 8'h44);
        host.frm_open();
        host.send(8'h05, 1'b0);
        host.recv();
        host.frm_close();
        chk("sr_read", rx, 8'h44);
        $display("t_vol done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        t_reset();
        t_addr();
        t_ext();
        t_sr();
        t_rst();
        t_cont();
        t_vol();
        report_and_stop();
    end
    // watchdog well beyond the expected run of about 150 microseconds
    initial
    begin
        #2000000;
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// File: test/sfmc_host.sv
`timescale 1ns/100ps
`default_nettype none
// spi host: link clock of 320 ns that stands low between frames
module sfmc_host (
    input  wire logic       clk_in,
    input  wire logic [3:0] dq_in,
    output logic            cs_n_out,
    output logic            sclk_out,
    output logic [3:0]      dq_out,
    output logic [3:0]      oe_out,
    output logic [7:0]      rx_out
);
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        dq_out   = 4'h0;
        oe_out   = 4'h0;
        rx_out   = 8'h00;
    end
    // one link clock: lanes move while sclk is low, read at the rise
    task automatic tick(input logic [3:0] oe, input logic [3:0] v);
        @(posedge clk_in);
        sclk_out <= 1'b0;
        oe_out   <= oe;
        dq_out   <= v;
        repeat (4) @(posedge clk_in);
        sclk_out <= 1'b1;
        rx_out   <= {rx_out[6:0], dq_in[1]};
        repeat (3) @(posedge clk_in);
    endtask
    // one byte on lane 0, or as two nibbles on all lanes
    task automatic send(input logic [7:0] b, input logic q);
        if (q)
        begin
            tick(4'hF, b[7:4]);
            tick(4'hF, b[3:0]);
        end
        else
            for (int i = 7; i >= 0; i--)
                tick(4'h1, {3'h0, b[i]});
    endtask
    task automatic recv;
        repeat (8) tick(4'h0, 4'h0);
    endtask
    task automatic frm_open;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
    endtask
    // clock parked low and lanes released before chip select rises
    task automatic frm_close;
        @(posedge clk_in);
        sclk_out <= 1'b0;
        oe_out   <= 4'h0;
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask
    task automatic put(input logic [7:0] b, input logic q);
        frm_open();
        send(b, q);
        frm_close();
    endtask
endmodule
`default_nettype wire
